//--- rtl/dccd_regs.svh
`ifndef DCCD_REGS_SVH
`define DCCD_REGS_SVH
// ----------------------------------------
// bus offsets
// ----------------------------------------
`define DCCD_OFF_CMD  4'h0
`define DCCD_OFF_DATA 4'h4
`define DCCD_OFF_STAT 4'h8
`define DCCD_OFF_LINE 4'hc
// ----------------------------------------
// command codes
// ----------------------------------------
`define DCCD_C_SLEEP_IN  8'h10
`define DCCD_C_SLEEP_OUT 8'h11
`define DCCD_C_TEAR_LINE 8'h44
`define DCCD_C_GET_LINE  8'h45
`define DCCD_C_READ_DESC 8'ha1
`define DCCD_C_MODE      8'hb0
`define DCCD_C_HORI      8'hb4
`define DCCD_C_VERT      8'hb6
`define DCCD_C_PIN_CONF  8'hb8
`define DCCD_C_PIN_VAL   8'hba
`define DCCD_C_PIN_STAT  8'hbb
`define DCCD_C_POST      8'hbc
`define DCCD_C_GEN_LO    8'hc0
`define DCCD_C_GEN_HI    8'hc7
`define DCCD_C_ROP_LO    8'hc8
`define DCCD_C_ROP_HI    8'hcf
`define DCCD_C_BL_CONF   8'hd0
`define DCCD_C_BL_LEVEL  8'hd4
`define DCCD_C_SYNTH_GO  8'he0
`define DCCD_C_SYNTH_MN  8'he2
`define DCCD_C_SYNTH_ST  8'he4
`define DCCD_C_DEEP      8'he5
`define DCCD_C_PIX_FREQ  8'he6
`define DCCD_C_HOST_FMT  8'hf0
// ----------------------------------------
// slots, fields, timing
// ----------------------------------------
`define DCCD_SLOT_GEN    5'h06
`define DCCD_SLOT_ROP    5'h0a
`define DCCD_SLOT_TEAR   5'h13
`define DCCD_PWR_BIT     7
`define DCCD_LOCK_NS     100000
`define DCCD_CLK_MHZ     20
`define DCCD_LOCK_CYC    ((`DCCD_LOCK_NS * `DCCD_CLK_MHZ + 999) / 1000)
`endif

//--- rtl/dccd_pkg.sv
package dccd_pkg;
  // avalon request bundle
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } dccd_av_req_t;
  // slot lookup result
  typedef struct packed {
    logic       hit;
    logic       is_set;
    logic [4:0] slot;
  } dccd_slot_t;
endpackage : dccd_pkg

//--- rtl/dccd_top.sv
`timescale 1ns/10ps
`include "dccd_regs.svh"
// Behaviour
// - 0x44 stores line, tear pulse there
// - 0x45 returns current scan line
// - 0xa1 returns descriptor from given start
// - 0xb0 sets, 0xb1 returns panel mode
// - 0xb4 sets, 0xb5 returns horizontal timing
// - 0xb6/0xb7 vertical timing, last line of frame
// - 0xb8 pin config, direction or panel
// - 0xba sets levels of output pins
// - 0xbb live input or programmed value
// - four generators, 0xc0-0xc7 set/get
// - 0xc8-0xce combine generators onto pins
// - 0xc9-0xcf return combine settings
// - 0xd0 sets, 0xd1 returns backlight config
// - 0xd4/0xd5 per-level saving thresholds
// - crystal clock until 0xe0 starts synth
// - 0xe2/0xe3 ratio, 0xe4 synth status
// - 0xe6/0xe7 pixel clock frequency
// - 0xf0/0xf1 host pixel format
// - 0xbc/0xbd post-processor config
// - sleep in/out drive pin0 low/high
module dccd_top
  import dccd_pkg::*;
#(
  parameter int  MAXP      = 8,
  parameter int  SLOTS     = 20,
  parameter [7:0] DESC_ID0 = 8'h5a,  // arbitrary value
  parameter [7:0] DESC_ID1 = 8'h3c   // arbitrary value
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire dccd_av_req_t av_req,
  output logic              waitrequest,
  output logic [31:0]       readdata,
  input  wire logic [3:0]   pin_i,
  output logic [3:0]        pin_o,
  output logic [3:0]        pin_oe_n,
  output logic              tear,
  output logic              frame_pulse,
  output logic              synth_sel,
  output logic              deep_sleep
);
  localparam int PW = $clog2(MAXP);
  localparam [15:0] LOCK_CYC = 16'(`DCCD_LOCK_CYC);

  // elaboration check
  if (MAXP < 4 || (1 << PW) != MAXP || SLOTS > 32 || SLOTS < 20) begin : g_bad_param
    $error("dccd_top: unsupported MAXP or SLOTS");
  end

  // ----------------------------------------
  // decode functions
  // ----------------------------------------
  // set codes are even, get codes are the odd neighbour
  function automatic dccd_slot_t slot_of(input logic [7:0] c);
    dccd_slot_t r;
    logic [7:0] e;
    r = '0;
    e = {c[7:1], 1'b0};
    r.is_set = ~c[0];
    r.hit = 1'b1;
    if (c >= `DCCD_C_GEN_LO && c <= `DCCD_C_GEN_HI) begin
      r.slot = `DCCD_SLOT_GEN + {3'h0, c[2:1]};
    end else if (c >= `DCCD_C_ROP_LO && c <= `DCCD_C_ROP_HI) begin
      r.slot = `DCCD_SLOT_ROP + {3'h0, c[2:1]};
    end else begin
      case (e)
        `DCCD_C_MODE:     r.slot = 5'h00;
        `DCCD_C_HORI:     r.slot = 5'h01;
        `DCCD_C_VERT:     r.slot = 5'h02;
        `DCCD_C_PIN_CONF: r.slot = 5'h03;
        `DCCD_C_PIN_VAL:  r.slot = 5'h04;
        `DCCD_C_POST:     r.slot = 5'h05;
        `DCCD_C_BL_CONF:  r.slot = 5'h0e;
        `DCCD_C_BL_LEVEL: r.slot = 5'h0f;
        `DCCD_C_SYNTH_MN: r.slot = 5'h10;
        `DCCD_C_PIX_FREQ: r.slot = 5'h11;
        `DCCD_C_HOST_FMT: r.slot = 5'h12;
        default:          r.hit = 1'b0;
      endcase
    end
    // tear line is write only
    if (c == `DCCD_C_TEAR_LINE) begin
      r = '{hit: 1'b1, is_set: 1'b1, slot: `DCCD_SLOT_TEAR};
    end
    return r;
  endfunction : slot_of

  // descriptor block contents
  function automatic logic [7:0] desc_byte(input logic [2:0] i);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      3'h0:    b = DESC_ID0;
      3'h1:    b = DESC_ID1;
      3'h2:    b = 8'(MAXP);
      3'h3:    b = 8'(SLOTS);
      default: b = 8'hff;
    endcase
    return b;
  endfunction : desc_byte

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        acc;
  logic        al;
  logic [1:0]  widx;
  assign acc  = (av_req.read | av_req.write) & ~wait_q;
  assign al   = av_req.address[1:0] == 2'b00;
  assign widx = av_req.address[3:2];

  logic        cmd_wr;
  logic        dat_wr;
  logic        dat_rd;
  assign cmd_wr = acc & av_req.write & al & av_req.byteenable[0] &
                  (av_req.address == `DCCD_OFF_CMD);
  assign dat_wr = acc & av_req.write & al & av_req.byteenable[0] &
                  (av_req.address == `DCCD_OFF_DATA);
  assign dat_rd = acc & av_req.read & al & (av_req.address == `DCCD_OFF_DATA);

  // one wait state, then the answer for one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((av_req.read | av_req.write) & wait_q);
    end
  end

  // ----------------------------------------
  // command engine
  // ----------------------------------------
  logic [7:0]    cmd_q;
  logic [PW-1:0] pidx_q;
  logic [7:0]    mem_q [SLOTS*MAXP];
  logic [2:0]    dbase_q;
  dccd_slot_t    cs;
  assign cs = slot_of(cmd_q);

  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_q  <= 8'h00;
      pidx_q <= '0;
    end else if (cmd_wr) begin
      cmd_q  <= av_req.writedata[7:0];
      pidx_q <= '0;
    end else if ((dat_wr | dat_rd) && pidx_q != PW'(MAXP - 1)) begin
      pidx_q <= pidx_q + PW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < SLOTS * MAXP; i++) begin
        mem_q[i] <= 8'h00;
      end
      mem_q[3 * MAXP] <= 8'h80;  // pin0 starts under sleep control
    end else if (dat_wr && cs.hit && cs.is_set) begin
      mem_q[{cs.slot, pidx_q}] <= av_req.writedata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dbase_q <= 3'h0;
    end else if (dat_wr && cmd_q == `DCCD_C_READ_DESC && pidx_q == '0) begin
      dbase_q <= av_req.writedata[2:0];
    end
  end

  // ----------------------------------------
  // synthesiser and deep sleep
  // ----------------------------------------
  logic        synth_q;
  logic        lock_q;
  logic [15:0] lcnt_q;
  logic        deep_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      synth_q <= 1'b0;
    end else if (dat_wr && cmd_q == `DCCD_C_SYNTH_GO && pidx_q == '0) begin
      synth_q <= av_req.writedata[0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst || !synth_q) begin
      lcnt_q <= 16'h0000;
      lock_q <= 1'b0;
    end else if (lcnt_q != LOCK_CYC) begin
      lcnt_q <= lcnt_q + 16'h0001;
    end else begin
      lock_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      deep_q <= 1'b0;
    end else if (cmd_wr) begin
      deep_q <= av_req.writedata[7:0] == `DCCD_C_DEEP;
    end
  end

  // ----------------------------------------
  // scan timing
  // ----------------------------------------
  logic [15:0] hcnt_q;
  logic [15:0] line_q;
  logic [15:0] ht;
  logic [15:0] vt;
  logic [15:0] tline;
  logic [15:0] lnext;
  logic        ltick;
  logic        tear_en_q;
  logic        tear_q;
  logic        fp_q;
  assign ht    = {mem_q[MAXP], mem_q[MAXP + 1]};
  assign vt    = {mem_q[2 * MAXP], mem_q[2 * MAXP + 1]};
  assign tline = {mem_q[`DCCD_SLOT_TEAR * MAXP], mem_q[`DCCD_SLOT_TEAR * MAXP + 1]};
  assign ltick = ~deep_q & (hcnt_q >= ht);
  assign lnext = (line_q >= vt) ? 16'h0000 : line_q + 16'h0001;

  // line and frame counters, halted in deep sleep
  always_ff @(posedge clock) begin
    if (rst) begin
      hcnt_q <= 16'h0000;
      line_q <= 16'h0000;
      fp_q   <= 1'b0;
    end else begin
      fp_q <= 1'b0;
      if (ltick) begin
        hcnt_q <= 16'h0000;
        if (line_q >= vt) begin
          line_q <= 16'h0000;
          fp_q   <= 1'b1;
        end else begin
          line_q <= line_q + 16'h0001;
        end
      end else if (!deep_q) begin
        hcnt_q <= hcnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tear_en_q <= 1'b0;
      tear_q    <= 1'b0;
    end else begin
      if (cmd_wr) begin
        tear_en_q <= (av_req.writedata[7:0] == `DCCD_C_TEAR_LINE) | tear_en_q;
      end
      tear_q <= tear_en_q & ltick & (lnext == tline);  // pulse as the stored line starts
    end
  end

  // ----------------------------------------
  // waveform units and pins
  // ----------------------------------------
  logic [3:0] gen;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] panel;
  logic [3:0] dir;
  logic [3:0] pval;
  logic [3:0] lvl;
  logic       pwr_q;
  logic [3:0] po_q;
  logic [3:0] poe_q;
  assign panel = mem_q[3 * MAXP][3:0];
  assign dir   = mem_q[3 * MAXP + 1][3:0];
  assign pval  = mem_q[4 * MAXP][3:0];

  for (genvar g = 0; g < 4; g++) begin : g_gen
    localparam int B = (`DCCD_SLOT_GEN + g) * MAXP;
    localparam int R = (`DCCD_SLOT_ROP + g) * MAXP;
    logic [7:0] gc_q;
    logic [15:0] tt;
    always_ff @(posedge clock) begin
      if (rst || gc_q >= mem_q[B]) begin
        gc_q <= 8'h00;
      end else begin
        gc_q <= gc_q + 8'h01;
      end
    end
    assign gen[g] = mem_q[B + 3][0] & (gc_q >= mem_q[B + 1]) & (gc_q < mem_q[B + 2]);
    assign tt     = {mem_q[R], mem_q[R + 1]};
    assign lvl[g] = panel[g] ? tt[gen] : pval[g];
  end

  // pin input synchroniser
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pwr_q <= 1'b0;
    end else if (cmd_wr && mem_q[3 * MAXP][`DCCD_PWR_BIT] && !panel[0]) begin
      if (av_req.writedata[7:0] == `DCCD_C_SLEEP_IN) begin
        pwr_q <= 1'b0;
      end else if (av_req.writedata[7:0] == `DCCD_C_SLEEP_OUT) begin
        pwr_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      po_q  <= 4'h0;
      poe_q <= 4'he;  // pin0 driven low under sleep control
    end else begin
      po_q  <= lvl;
      poe_q <= ~(dir | panel);
      if (mem_q[3 * MAXP][`DCCD_PWR_BIT] && !panel[0]) begin
        po_q[0]  <= pwr_q;
        poe_q[0] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [7:0] pbyte;
  always_comb begin
    pbyte = 8'h00;
    if (cs.hit && !cs.is_set && cmd_q != `DCCD_C_PIN_STAT) begin
      pbyte = mem_q[{cs.slot, pidx_q}];
    end else begin
      case (cmd_q)
        `DCCD_C_GET_LINE:  pbyte = (pidx_q == '0) ? line_q[15:8] : line_q[7:0];
        `DCCD_C_READ_DESC: pbyte = desc_byte(dbase_q + 3'(pidx_q) - 3'h1);  // start write counted
        `DCCD_C_PIN_STAT:  pbyte = {4'h0, (dir | panel) & po_q | ~(dir | panel) & pin_s2_q};
        `DCCD_C_SYNTH_ST:  pbyte = {7'h00, lock_q};
        default:           pbyte = 8'h00;
      endcase
    end
  end

  // registered answer, zero for unmapped
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (av_req.read && wait_q) begin
      rdata_q <= 32'h0000_0000;
      if (al) begin
        case (widx)
          2'h0:    rdata_q <= {24'h0, cmd_q};
          2'h1:    rdata_q <= {24'h0, pbyte};
          2'h2:    rdata_q <= 32'({pidx_q, lock_q, synth_q, deep_q});
          default: rdata_q <= {16'h0, line_q};
        endcase
      end
    end
  end

  assign waitrequest = wait_q;
  assign readdata    = rdata_q;
  assign pin_o       = po_q;
  assign pin_oe_n    = poe_q;
  assign tear        = tear_q;
  assign frame_pulse = fp_q;
  assign synth_sel   = synth_q;
  assign deep_sleep  = deep_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // bus answer release
  bus_release_a: assert property (@(posedge clock) disable iff (rst)
    acc |=> wait_q) else $error("waitrequest not raised after answer");
  cmd_index_a: assert property (@(posedge clock) disable iff (rst)
    cmd_wr |=> pidx_q == '0 && cmd_q == $past(av_req.writedata[7:0]))
    else $error("command write not taken");
  tear_line_a: assert property (@(posedge clock) disable iff (rst)
    tear_q |-> $past(ltick) && $past(lnext) == $past(tline) && $past(tear_en_q))
    else $error("tear pulse on wrong line");
  deep_entry_a: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && av_req.writedata[7:0] == `DCCD_C_DEEP |=> deep_q ##1 ltick == 1'b0)
    else $error("deep sleep not entered");
  lock_wait_a: assert property (@(posedge clock) disable iff (rst)
    $rose(synth_q) |-> !lock_q [*8]) else $error("lock reported too early");
  sleep_pin_a: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && av_req.writedata[7:0] == `DCCD_C_SLEEP_IN && mem_q[3 * MAXP][`DCCD_PWR_BIT]
    && !panel[0] |=> ##1 !po_q[0] && !poe_q[0]) else $error("pin0 not pulled low");
  pin_dir_a: assert property (@(posedge clock) disable iff (rst)
    ##1 poe_q[3:1] == $past(~(dir[3:1] | panel[3:1]))) else $error("pin enable wrong");
  unmapped_zero_a: assert property (@(posedge clock) disable iff (rst)
    av_req.read && wait_q && !al |=> rdata_q == 32'h0) else $error("unmapped read not zero");
  // frame pulse at line wrap
  frame_wrap_a: assert property (@(posedge clock) disable iff (rst)
    fp_q |-> line_q == 16'h0) else $error("frame pulse off line zero");
endmodule : dccd_top

//--- tb/dccd_host.sv
`timescale 1ns/10ps
// ----------------------------------------
// host bus master model
// ----------------------------------------
module dccd_host
  import dccd_pkg::*;
(
  input  wire logic        clock,
  output dccd_av_req_t     av_req,
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata
);
  initial av_req = '0;
  // one byte per access
  // hold request until waitrequest low, then release with scrambled lines
  task automatic xfer(input logic wr, input logic [3:0] addr, input logic [7:0] wdata,
                      output logic [31:0] rdata);
    @(posedge clock);
    av_req.read       <= ~wr;
    av_req.write      <= wr;
    av_req.address    <= addr;
    av_req.writedata  <= {24'h00_0000, wdata};
    av_req.byteenable <= 4'hf;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rdata = readdata;
    av_req.read      <= 1'b0;
    av_req.write     <= 1'b0;
    av_req.address   <= ~addr;  // released lines do not keep old value
    av_req.writedata <= {24'hff_ffff, ~wdata};
  endtask : xfer
endmodule : dccd_host

//--- tb/testbench.sv
`timescale 1ns/10ps
`include "dccd_regs.svh"
module testbench;
  import dccd_pkg::*;
  logic         clock = 1'b0;
  logic         rst   = 1'b1;
  dccd_av_req_t av_req;
  logic         waitrequest, tear, frame_pulse, synth_sel, deep_sleep;
  logic [31:0]  readdata, v;
  logic [3:0]   pin_o, pin_oe_n, ext = 4'h8;
  wire  [3:0]   pin_w = (~pin_oe_n & pin_o) | (pin_oe_n & ext);
  logic [7:0]   b;
  int           fail_count = 0, n_checks = 0, cyc = 0;
  int           t_tear = 0, t_tear_p = 0, t_frm = 0, t_frm_p = 0, per;
  logic [7:0]   codes [13] = '{8'hb0, 8'hb4, 8'hb6, 8'hbc, 8'hc0, 8'hc2, 8'hc4,
                               8'hc6, 8'hd0, 8'hd4, 8'he2, 8'he6, 8'hf0};
  always #25 clock = ~clock;
  dccd_top dut (.clock(clock), .rst(rst), .av_req(av_req), .waitrequest(waitrequest),
    .readdata(readdata), .pin_i(pin_w), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .tear(tear),
    .frame_pulse(frame_pulse), .synth_sel(synth_sel), .deep_sleep(deep_sleep));
  dccd_host host (.clock(clock), .av_req(av_req), .waitrequest(waitrequest),
    .readdata(readdata));
  // cycle count, pulse times and hang limit
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (tear === 1'b1) begin t_tear_p <= t_tear; t_tear <= cyc; end
    if (frame_pulse === 1'b1) begin t_frm_p <= t_frm; t_frm <= cyc; end
    if (cyc == 9000) begin fail_count++; summarize(); end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic cmd(input logic [7:0] c); host.xfer(1'b1, `DCCD_OFF_CMD, c, v); endtask : cmd
  task automatic par(input logic [7:0] d); host.xfer(1'b1, `DCCD_OFF_DATA, d, v); endtask : par
  task automatic get(output logic [7:0] d);
    host.xfer(1'b0, `DCCD_OFF_DATA, 8'h00, v);
    d = v[7:0];
  endtask : get
  task automatic rreg(input logic [3:0] a); host.xfer(1'b0, a, 8'h00, v); endtask : rreg
  task automatic settle(); repeat (3) @(posedge clock); #1; endtask : settle
  function automatic logic [7:0] pat(input int i, input int j);
    return 8'(8'h11 * (j + 1) + i);
  endfunction : pat
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    #1;
    check("oe reset", {28'h0, pin_oe_n}, 32'h0000_000e);
    check("out reset", {30'h0, synth_sel, deep_sleep}, 32'h0);
    rreg(4'h2);
    check("misaligned read", v, 32'h0);
    // set then get round trips over 13 set/get pairs, not 0xb8, 0xba or 0xc8-0xce
    for (int i = 0; i < 13; i++) begin
      cmd(codes[i]);
      for (int j = 0; j < 3; j++) par(pat(i, j));
      cmd(8'(codes[i] + 8'h01));
      for (int j = 0; j < 3; j++) begin
        get(b);
        check("round trip", {24'h0, b}, {24'h0, pat(i, j)});
      end
    end
    // reserved code takes bytes silently
    cmd(8'ha8);
    par(8'h55);
    get(b);
    check("reserved read", {24'h0, b}, 32'h0);
    // descriptor read from start location 2
    cmd(`DCCD_C_READ_DESC);
    par(8'h02);
    get(b);
    check("desc start", {24'h0, b}, 32'h8);
    get(b);
    check("desc next", {24'h0, b}, 32'h14);
    // general pins: pins 0,1 out, 2,3 in
    cmd(`DCCD_C_PIN_CONF);
    par(8'h00);
    par(8'h03);
    settle();
    check("pin dir", {28'h0, pin_oe_n}, 32'h0000_000c);
    cmd(8'hb9);
    get(b);
    check("conf b0", {24'h0, b}, 32'h0);
    get(b);
    check("conf b1", {24'h0, b}, 32'h3);
    cmd(`DCCD_C_PIN_VAL);
    par(8'h02);
    settle();
    check("pin val", {30'h0, pin_o[1:0]}, 32'h2);
    for (int k = 0; k < 2; k++) begin
      ext <= k ? 4'h4 : 4'h8;
      settle();
      cmd(`DCCD_C_PIN_STAT);
      get(b);
      check("pin stat", {28'h0, b[3:0]}, k ? 32'h6 : 32'ha);
    end
    // sleep codes drive pin0 under sleep control
    cmd(`DCCD_C_PIN_CONF);
    par(8'h80);
    par(8'h00);
    cmd(`DCCD_C_SLEEP_OUT);
    settle();
    check("sleep out", {30'h0, pin_oe_n[0], pin_o[0]}, 32'h1);
    cmd(`DCCD_C_SLEEP_IN);
    settle();
    check("sleep in", {30'h0, pin_oe_n[0], pin_o[0]}, 32'h0);
    // combine: pin0 panel, pin1 general output high
    cmd(`DCCD_C_PIN_CONF);
    par(8'h01);
    par(8'h02);
    cmd(`DCCD_C_PIN_VAL);
    par(8'h02);
    for (int k = 0; k < 2; k++) begin
      cmd(`DCCD_C_ROP_LO);
      par(k ? 8'h00 : 8'hff);
      par(k ? 8'h00 : 8'hff);
      settle();
      check("combine pin0", {31'h0, pin_o[0]}, k ? 32'h0 : 32'h1);
      cmd(8'hc9);
      get(b);
      check("combine get", {24'h0, b}, k ? 32'h0 : 32'hff);
    end
    // generator 0 high two of four clocks, pin0 follows it
    cmd(8'hc0);
    par(8'h03);
    par(8'h01);
    par(8'h03);
    par(8'h01);
    cmd(`DCCD_C_ROP_LO);
    par(8'haa);
    par(8'haa);
    settle();
    per = 0;
    repeat (8) begin @(posedge clock); #1; per += pin_o[0]; end
    check("gen duty", per, 4);
    cmd(8'hca);
    par(8'h00);
    par(8'h00);
    settle();
    check("combine general", {31'h0, pin_o[1]}, 32'h1);
    // scan timing: 10 clocks per line, tear at line 2
    cmd(`DCCD_C_HORI);
    par(8'h00);
    par(8'h09);
    cmd(`DCCD_C_VERT);
    par(8'h00);
    par(8'h04);
    cmd(`DCCD_C_TEAR_LINE);
    par(8'h00);
    par(8'h02);
    repeat (300) @(posedge clock);
    per = t_frm - t_frm_p;
    check("frame seen", {31'h0, per > 0}, 32'h1);
    check("tear period", t_tear - t_tear_p, per);
    if (per > 0) check("tear line", ((t_tear - t_frm + per) % per) / 10, 2);
    cmd(`DCCD_C_GET_LINE);
    get(b);
    check("line high", {24'h0, b}, 32'h0);
    get(b);
    check("line low range", {31'h0, b <= 8'h04}, 32'h1);
    // synthesiser start and lock
    cmd(`DCCD_C_SYNTH_GO);
    par(8'h01);
    settle();
    check("synth sel", {31'h0, synth_sel}, 32'h1);
    cmd(`DCCD_C_SYNTH_ST);
    get(b);
    check("not locked", {31'h0, b[0]}, 32'h0);
    repeat (`DCCD_LOCK_CYC + 50) @(posedge clock);
    cmd(`DCCD_C_SYNTH_ST);
    get(b);
    check("locked", {31'h0, b[0]}, 32'h1);
    rreg(`DCCD_OFF_STAT);
    check("stat synth", {30'h0, v[2:1]}, 32'h3);
    // deep sleep until next command
    cmd(`DCCD_C_DEEP);
    settle();
    check("deep on", {31'h0, deep_sleep}, 32'h1);
    rreg(`DCCD_OFF_STAT);
    check("stat deep", {31'h0, v[0]}, 32'h1);
    cmd(8'h00);
    settle();
    check("deep off", {31'h0, deep_sleep}, 32'h0);
    summarize();
  end
endmodule : testbench
